/* three_port_parallel_io_tb_top.sv */
`timescale 1ns/1ps
module three_port_parallel_io_tb_top;
    logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, line_level;
    logic        fast_osc_clock = 1'b0;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0]  pstrb;
    logic [6:0]  pa_in, pa_out, pa_oe_n, pa_pull_up, keypad_inputs, ext_a;
    logic [7:0]  pb_in, pb_out, pb_oe_n, ext_b;
    logic [2:0]  pc_in, pc_pull_up, ext_c;
    logic [1:0]  pc_out, pc_oe_n;
    int          errors, checks_done;
    tpio_ports dut_u (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .pa_in, .pa_out, .pa_oe_n, .pa_pull_up, .pb_in, .pb_out, .pb_oe_n, .pc_in, .pc_out, .pc_oe_n,
        .pc_pull_up, .fast_osc_clock, .keypad_inputs, .line_level);
    tpio_pins pins_u (.pa_out, .pa_oe_n, .pa_pull_up, .ext_a, .pa_in, .pb_out, .pb_oe_n, .ext_b, .pb_in,
        .pc_out, .pc_oe_n, .pc_pull_up, .ext_c, .pc_in);
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Free-running clock at half the sys_clk rate for the oscillator output pin
    always @(posedge sys_clk) fast_osc_clock <= ~fast_osc_clock;
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // One APB transfer; pready is read before the edge's updates land
    task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] d, output logic [31:0] q, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {26'h0, i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            summarize();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, i, d, q, e);
    endtask
    task automatic rd(input logic [3:0] i, input logic [7:0] x);
        logic [31:0] q;
        logic        e;
        apb(1'b0, i, 8'h00, q, e);
        chk(q, {24'h0, x});
    endtask
    // Main sequence
    initial begin
        logic [31:0] q;
        logic        e;
        logic        b;
        {rst, psel, penable, pwrite} = 4'b1000;
        {paddr, pwdata, pstrb} = {64'h0, 4'h1};
        {ext_a, ext_b, ext_c} = {7'h2A, 8'h3C, 3'h4};
        errors = 0;
        checks_done = 0;
        cyc(12);
        rst <= 1'b0;
        cyc(1);
        rd(4'h4, 8'h00);
        rd(4'h6, 8'h00);
        wr(4'h0, 8'h55); // latch before direction
        wr(4'h4, 8'h7F);
        rd(4'h0, 8'h55);
        cyc(2);
        chk(32'(pa_out), 32'h55);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        chk(32'(pa_oe_n), 32'h7F);
        // Synchronisers restart from zero and need two edges for the pins
        cyc(2);
        rd(4'h0, 8'h2A);
        wr(4'h4, 8'h7F);
        rd(4'h0, 8'h55);
        wr(4'h4, 8'h00);
        wr(4'h0, 8'h33);
        rd(4'h0, 8'h2A);
        wr(4'h4, 8'hFF);
        rd(4'h0, 8'h33);
        rd(4'h4, 8'h7F);
        $display("test port_a done");
        wr(4'h4, 8'h0F);
        wr(4'h8, 8'hFF);
        rd(4'h8, 8'h7F);
        ext_a <= 7'h00;
        cyc(3);
        chk(32'(pa_pull_up), 32'h70);
        rd(4'h0, 8'h73);
        wr(4'h8, 8'h00);
        cyc(3);
        rd(4'h0, 8'h03);
        wr(4'hA, 8'h01);
        cyc(4);
        chk(32'(keypad_inputs), 32'h01);
        $display("test pullup_keypad done");
        wr(4'h1, 8'hA5);
        wr(4'h5, 8'h0F);
        rd(4'h1, 8'h35);
        chk(32'(pb_oe_n), 32'hF0);
        chk(32'(pb_out), 32'hA5);
        $display("test port_b done");
        wr(4'h6, 8'hFF);
        rd(4'h6, 8'h03);
        // A write without the low byte strobe must be ignored
        pstrb <= 4'h0;
        wr(4'h6, 8'h00);
        pstrb <= 4'h1;
        rd(4'h6, 8'h03);
        wr(4'h2, 8'h07);
        rd(4'h2, 8'h07);
        chk(32'(pc_out), 32'h3);
        chk(32'(pc_oe_n), 32'h0);
        chk(32'(line_level), 32'h1);
        wr(4'hB, 8'h01);
        rd(4'h2, 8'h03);
        ext_c <= 3'h0;
        cyc(4);
        chk(32'(line_level), 32'h0);
        wr(4'h6, 8'h01);
        wr(4'h9, 8'h87);
        // Internal and RC modes drive the clock, external and crystal do not
        for (int m = 0; m < 4; m++) begin
            wr(4'hB, 8'(m * 2 + 1));
            cyc(3);
            chk(32'(pc_oe_n[1]), 32'(m % 2));
            chk(32'(pc_pull_up), (m % 2 == 1) ? 32'h6 : 32'h4);
            b = pc_out[1];
            cyc(1);
            chk(32'(pc_out[1]), (m % 2 == 1) ? 32'h1 : 32'(!b));
        end
        $display("test port_c done");
        apb(1'b0, 4'h3, 8'h00, q, e);
        chk(32'(e), 32'h1);
        chk(q, 32'h0);
        $display("test unmapped done");
        summarize();
    end
endmodule

/* tpio_pins_model.sv */
`timescale 1ns/1ps
module tpio_pins (
    input  wire logic [6:0] pa_out,
    input  wire logic [6:0] pa_oe_n,
    input  wire logic [6:0] pa_pull_up,
    input  wire logic [6:0] ext_a,
    output logic      [6:0] pa_in,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe_n,
    input  wire logic [7:0] ext_b,
    output logic      [7:0] pb_in,
    input  wire logic [1:0] pc_out,
    input  wire logic [1:0] pc_oe_n,
    input  wire logic [2:0] pc_pull_up,
    input  wire logic [2:0] ext_c,
    output logic      [2:0] pc_in
);
    // Board is weak: a driven pin wins, then an attached pullup
    // driver, pullup, board
    assign pa_in = (pa_out & ~pa_oe_n) | (pa_oe_n & (pa_pull_up | ext_a));
    assign pb_in = (pb_out & ~pb_oe_n) | (pb_oe_n & ext_b);
    assign pc_in = {pc_pull_up[2] | ext_c[2], (pc_out & ~pc_oe_n) | (pc_oe_n & (pc_pull_up[1:0] | ext_c[1:0]))};
endmodule

/* tpio_pkg.sv */
package tpio_pkg;

    // -------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // -------------------------------------------------------------------
    localparam logic [3:0] IDX_PORT_A_DATA      = 4'h0;
    localparam logic [3:0] IDX_PORT_B_DATA      = 4'h1;
    localparam logic [3:0] IDX_PORT_C_DATA      = 4'h2;
    localparam logic [3:0] IDX_PORT_A_DIRECTION = 4'h4;
    localparam logic [3:0] IDX_PORT_B_DIRECTION = 4'h5;
    localparam logic [3:0] IDX_PORT_C_DIRECTION = 4'h6;
    localparam logic [3:0] IDX_PORT_A_PULLUP    = 4'h8;
    localparam logic [3:0] IDX_PORT_C_PULLUP    = 4'h9;
    localparam logic [3:0] IDX_KEYPAD_ENABLE    = 4'hA;
    localparam logic [3:0] IDX_OPTION_WORD_TWO  = 4'hB;

    // -------------------------------------------------------------------
    // Port widths
    // -------------------------------------------------------------------
    localparam int PA_W    = 7;
    localparam int PB_W    = 8;
    localparam int PC_W    = 3;
    localparam int PC_DIRW = 2;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int POS_OSC_OUT_SEL = 7;  // in port C pullup register
    localparam int POS_IRQ_ENABLE  = 0;  // in option word two
    localparam int POS_OSC_MODE    = 1;  // two bits, in option word two
    localparam int POS_OSC_PIN     = 1;  // port C pin that can carry the clock
    localparam int POS_INPUT_ONLY  = 2;  // port C input-only pin

    // Oscillator mode encodings
    localparam logic [1:0] OSC_INTERNAL = 2'h0;
    localparam logic [1:0] OSC_EXTERNAL = 2'h1;
    localparam logic [1:0] OSC_RC       = 2'h2;
    localparam logic [1:0] OSC_CRYSTAL  = 2'h3;

    // -------------------------------------------------------------------
    // Values after reset
    // -------------------------------------------------------------------
    localparam logic [7:0]  RST_DIR    = 8'h00;
    localparam logic [7:0]  RST_PULLUP = 8'h00;
    localparam logic [6:0]  RST_KEYPAD = 7'h00;
    localparam logic [2:0]  RST_OPTION = 3'h0;
    localparam logic [31:0] RST_RDATA  = 32'h0000_0000;
    localparam logic [7:0]  RST_OE_N   = 8'hFF;
    localparam logic        RST_LINE   = 1'b1;
    localparam logic [7:0]  RST_SYNC   = 8'h00;

endpackage

/* tpio_ports.sv */
`timescale 1ns/1ps
// Functional notes
// [RQ1] Direction one drives latch, zero releases pin
// [RQ2] Reset clears every direction bit
// [RQ3] Reset leaves data latches untouched
// [RQ4] Output bits of port A read latch
// [RQ5] Input bits read synchronised pin level
// [RQ6] Data writes always update latches
// [RQ7] Port A has seven full pins
// [RQ8] Port B eight pins, no pullups
// [RQ9] Port C three pins, top input-only
// [RQ10] Only two lowest port C direction bits
// [RQ11] Pullup only when enabled and input
// [RQ12] Pullup enable one attaches, zero detaches
// [RQ13] Interrupt enabled forces port C bit2 zero
// [RQ14] Line level true only when interrupt enabled; the code forces line_level high while the interrupt is off
// [RQ15] Software writes latch before setting direction
// [RQ16] Keypad enable routes port A pin to interrupt
// [RQ17] Port C data at index two
// [RQ18] Oscillator select puts fast clock on pin; the code does so only in internal or RC oscillator mode
// [RQ19] Unimplemented bits read zero, ignore writes
module tpio_ports (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [6:0]  pa_in,
    output logic      [6:0]  pa_out,
    output logic      [6:0]  pa_oe_n,
    output logic      [6:0]  pa_pull_up,
    input  wire logic [7:0]  pb_in,
    output logic      [7:0]  pb_out,
    output logic      [7:0]  pb_oe_n,
    input  wire logic [2:0]  pc_in,
    output logic      [1:0]  pc_out,
    output logic      [1:0]  pc_oe_n,
    output logic      [2:0]  pc_pull_up,
    input  wire logic        fast_osc_clock,
    output logic      [6:0]  keypad_inputs,
    output logic             line_level
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    // Every pin is asynchronous to sys_clk, so each gets two flops.
    // The first stage feeds only the second; nothing else reads it.
    logic [6:0] pa_meta;
    logic [6:0] pa_sync;
    logic [7:0] pb_meta;
    logic [7:0] pb_sync;
    logic [2:0] pc_meta;
    logic [2:0] pc_sync;
    logic       osc_meta;
    logic       osc_sync;

    // Port A pins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pa_meta <= tpio_pkg::RST_SYNC[6:0];
            pa_sync <= tpio_pkg::RST_SYNC[6:0];
        end else begin
            pa_meta <= pa_in;
            pa_sync <= pa_meta;
        end
    end

    // Port B pins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pb_meta <= tpio_pkg::RST_SYNC;
            pb_sync <= tpio_pkg::RST_SYNC;
        end else begin
            pb_meta <= pb_in;
            pb_sync <= pb_meta;
        end
    end

    // Port C pins, the input-only pin included
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pc_meta <= tpio_pkg::RST_SYNC[2:0];
            pc_sync <= tpio_pkg::RST_SYNC[2:0];
        end else begin
            pc_meta <= pc_in;
            pc_sync <= pc_meta;
        end
    end

    // Fast oscillator clock; sampled by sys_clk, so the copy on the
    // pin is only as fine as the system clock allows
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_meta <= tpio_pkg::RST_SYNC[0];
            osc_sync <= tpio_pkg::RST_SYNC[0];
        end else begin
            osc_meta <= fast_osc_clock;
            osc_sync <= osc_meta;
        end
    end

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic [6:0] port_a_latch;
    logic [7:0] port_b_latch;
    logic [2:0] port_c_latch;
    logic [6:0] port_a_dir;
    logic [7:0] port_b_dir;
    logic [1:0] port_c_dir;
    logic [6:0] port_a_pull_en;
    logic [2:0] port_c_pull_en;
    logic       osc_clock_out_select;
    logic [6:0] keypad_irq_enables;
    logic       irq_enable;
    logic [1:0] osc_mode;

    // APB decode
    logic       wr_fire;
    logic       setup;
    logic [3:0] idx;
    logic       lane0;
    logic       mapped;

    assign wr_fire = psel & penable & pready & pwrite;
    assign setup   = psel & ~penable;
    assign idx     = paddr[5:2];
    // Only the low byte lane carries data; upper lanes are reserved
    assign lane0   = pstrb[0];

    // Address decode for the mapped words
    always_comb begin
        if (paddr[31:6] != 26'h0 || paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else if (idx == tpio_pkg::IDX_PORT_A_DATA || idx == tpio_pkg::IDX_PORT_B_DATA) begin
            mapped = 1'b1;
        end else if (idx == tpio_pkg::IDX_PORT_C_DATA || idx == tpio_pkg::IDX_PORT_A_DIRECTION) begin
            mapped = 1'b1;
        end else if (idx == tpio_pkg::IDX_PORT_B_DIRECTION || idx == tpio_pkg::IDX_PORT_C_DIRECTION) begin
            mapped = 1'b1;
        end else if (idx == tpio_pkg::IDX_PORT_A_PULLUP || idx == tpio_pkg::IDX_PORT_C_PULLUP) begin
            mapped = 1'b1;
        end else if (idx == tpio_pkg::IDX_KEYPAD_ENABLE || idx == tpio_pkg::IDX_OPTION_WORD_TWO) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Data latches
    // ---------------------------------------------------------------
    // No reset term: latches hold their value across reset
    // [RQ3] latches keep value
    always_ff @(posedge sys_clk) begin
        if (wr_fire && lane0 && mapped) begin
            // [RQ6] writes always land
            if (idx == tpio_pkg::IDX_PORT_A_DATA) begin
                port_a_latch <= pwdata[6:0];
            end else if (idx == tpio_pkg::IDX_PORT_B_DATA) begin
                port_b_latch <= pwdata[7:0];
            // [RQ17] port C data word
            end else if (idx == tpio_pkg::IDX_PORT_C_DATA) begin
                port_c_latch <= pwdata[2:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Direction, pullup and option registers
    // ---------------------------------------------------------------
    // [RQ2] directions cleared
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_a_dir           <= tpio_pkg::RST_DIR[6:0];
            port_b_dir           <= tpio_pkg::RST_DIR;
            port_c_dir           <= tpio_pkg::RST_DIR[1:0];
            port_a_pull_en       <= tpio_pkg::RST_PULLUP[6:0];
            port_c_pull_en       <= tpio_pkg::RST_PULLUP[2:0];
            osc_clock_out_select <= tpio_pkg::RST_PULLUP[tpio_pkg::POS_OSC_OUT_SEL];
            keypad_irq_enables   <= tpio_pkg::RST_KEYPAD;
            irq_enable           <= tpio_pkg::RST_OPTION[tpio_pkg::POS_IRQ_ENABLE];
            osc_mode             <= tpio_pkg::RST_OPTION[tpio_pkg::POS_OSC_MODE +: 2];
        end else if (wr_fire && lane0 && mapped) begin
            // Unmapped addresses must leave every register alone
            // [RQ19] unused bits dropped
            if (idx == tpio_pkg::IDX_PORT_A_DIRECTION) begin
                port_a_dir <= pwdata[6:0];
            end else if (idx == tpio_pkg::IDX_PORT_B_DIRECTION) begin
                port_b_dir <= pwdata[7:0];
            // [RQ10] two direction bits
            end else if (idx == tpio_pkg::IDX_PORT_C_DIRECTION) begin
                port_c_dir <= pwdata[1:0];
            end else if (idx == tpio_pkg::IDX_PORT_A_PULLUP) begin
                port_a_pull_en <= pwdata[6:0];
            end else if (idx == tpio_pkg::IDX_PORT_C_PULLUP) begin
                port_c_pull_en       <= pwdata[2:0];
                osc_clock_out_select <= pwdata[tpio_pkg::POS_OSC_OUT_SEL];
            end else if (idx == tpio_pkg::IDX_KEYPAD_ENABLE) begin
                keypad_irq_enables <= pwdata[6:0];
            end else if (idx == tpio_pkg::IDX_OPTION_WORD_TWO) begin
                irq_enable <= pwdata[tpio_pkg::POS_IRQ_ENABLE];
                osc_mode   <= pwdata[tpio_pkg::POS_OSC_MODE +: 2];
            end
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    logic [7:0] pa_view;
    logic [7:0] pb_view;
    logic [7:0] pc_view;
    logic [7:0] rd_byte;

    // Per bit: latch when output, synchronised pin when input
    always_comb begin
        // [RQ4] output bits read latch
        // [RQ5] input bits read pin
        pa_view = {1'b0, (port_a_dir & port_a_latch) | (~port_a_dir & pa_sync)};
        pb_view = (port_b_dir & port_b_latch) | (~port_b_dir & pb_sync);
        pc_view = 8'h00;
        pc_view[1:0] = (port_c_dir & port_c_latch[1:0]) | (~port_c_dir & pc_sync[1:0]);
        // [RQ13] bit2 masked by interrupt
        pc_view[tpio_pkg::POS_INPUT_ONLY] = irq_enable ? 1'b0 : pc_sync[tpio_pkg::POS_INPUT_ONLY];
    end

    // Read decode; unmapped words read zero
    always_comb begin
        rd_byte = 8'h00;
        if (idx == tpio_pkg::IDX_PORT_A_DATA) begin
            rd_byte = pa_view;
        end else if (idx == tpio_pkg::IDX_PORT_B_DATA) begin
            rd_byte = pb_view;
        end else if (idx == tpio_pkg::IDX_PORT_C_DATA) begin
            rd_byte = pc_view;
        end else if (idx == tpio_pkg::IDX_PORT_A_DIRECTION) begin
            rd_byte = {1'b0, port_a_dir};
        end else if (idx == tpio_pkg::IDX_PORT_B_DIRECTION) begin
            rd_byte = port_b_dir;
        end else if (idx == tpio_pkg::IDX_PORT_C_DIRECTION) begin
            rd_byte = {6'h00, port_c_dir};
        end else if (idx == tpio_pkg::IDX_PORT_A_PULLUP) begin
            rd_byte = {1'b0, port_a_pull_en};
        end else if (idx == tpio_pkg::IDX_PORT_C_PULLUP) begin
            rd_byte = {osc_clock_out_select, 4'h0, port_c_pull_en};
        end else if (idx == tpio_pkg::IDX_KEYPAD_ENABLE) begin
            rd_byte = {1'b0, keypad_irq_enables};
        end else if (idx == tpio_pkg::IDX_OPTION_WORD_TWO) begin
            rd_byte = {5'h00, osc_mode, irq_enable};
        end
    end

    // ---------------------------------------------------------------
    // APB answer
    // ---------------------------------------------------------------
    // Answer is prepared in setup so the access phase ends in one cycle
    // Reads and writes alike answer at once; there are no wait states
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata  <= tpio_pkg::RST_RDATA;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= (mapped && !pwrite) ? {24'h00_0000, rd_byte} : tpio_pkg::RST_RDATA;
            pready  <= 1'b1;
            pslverr <= ~mapped;
        end else begin
            prdata  <= tpio_pkg::RST_RDATA;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Pin drivers
    // ---------------------------------------------------------------
    logic osc_on_pin;

    // Clock only reaches the pin with internal or RC oscillator
    // [RQ18] oscillator clock out
    assign osc_on_pin = osc_clock_out_select &&
                        (osc_mode == tpio_pkg::OSC_INTERNAL || osc_mode == tpio_pkg::OSC_RC);

    // Registered pad data; latches pass through one flop stage.
    // Drive data may be unknown after power-up, but enables stay off.
    // [RQ1] pin drives latch
    always_ff @(posedge sys_clk) begin
        pa_out    <= port_a_latch;
        pb_out    <= port_b_latch;
        pc_out[0] <= port_c_latch[0];
        // Oscillator output overrides the latch on the middle pin
        pc_out[1] <= osc_on_pin ? osc_sync : port_c_latch[1];
    end

    // ---------------------------------------------------------------
    // Output enables and pullups
    // ---------------------------------------------------------------
    // Setting a direction before its latch can glitch the pin; that
    // order is up to software, the pads simply follow both registers.

    // Port A pads
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pa_oe_n    <= tpio_pkg::RST_OE_N[6:0];
            pa_pull_up <= tpio_pkg::RST_PULLUP[6:0];
        end else begin
            // [RQ7] seven port A pins
            // [RQ1] enable follows direction
            pa_oe_n    <= ~port_a_dir;
            // [RQ11] pullup off when output
            // [RQ12] enable attaches pullup
            pa_pull_up <= port_a_pull_en & ~port_a_dir;
        end
    end

    // Port B pads have no pullup; an input pin simply floats
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pb_oe_n <= tpio_pkg::RST_OE_N;
        end else begin
            // [RQ8] eight pins, no pullup
            pb_oe_n <= ~port_b_dir;
        end
    end

    // Port C pads
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pc_oe_n    <= tpio_pkg::RST_OE_N[1:0];
            pc_pull_up <= tpio_pkg::RST_PULLUP[2:0];
        end else begin
            // [RQ9] bit2 never driven
            pc_oe_n[0]    <= ~port_c_dir[0];
            // Oscillator output needs the driver on even for an input
            pc_oe_n[1]    <= ~(port_c_dir[1] | osc_on_pin);
            // [RQ11] pullup off when driven
            pc_pull_up[0] <= port_c_pull_en[0] & ~port_c_dir[0];
            pc_pull_up[1] <= port_c_pull_en[1] & ~port_c_dir[1] & ~osc_on_pin;
            // Input-only pin takes its pullup whatever the direction
            pc_pull_up[2] <= port_c_pull_en[2];
        end
    end

    // ---------------------------------------------------------------
    // Keypad routing and interrupt line level
    // ---------------------------------------------------------------
    // [RQ16] keypad pins gated
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            keypad_inputs <= tpio_pkg::RST_KEYPAD;
        end else begin
            keypad_inputs <= keypad_irq_enables & pa_sync;
        end
    end

    // Branches see the pin only while the interrupt is on; otherwise
    // the line reads high, so a branch on low is never taken
    // [RQ14] level or forced high
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            line_level <= tpio_pkg::RST_LINE;
        end else begin
            line_level <= irq_enable ? pc_sync[tpio_pkg::POS_INPUT_ONLY] : 1'b1;
        end
    end

endmodule

/* tpio_ports_asserts.sv */
`timescale 1ns/1ps
module tpio_ports_chk (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [6:0]  pa_out,
    input wire logic [6:0]  pa_oe_n,
    input wire logic [6:0]  pa_pull_up,
    input wire logic [7:0]  pb_oe_n,
    input wire logic [1:0]  pc_oe_n,
    input wire logic [6:0]  keypad_inputs,
    input wire logic        line_level
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Committed write, and a shadow of the options it sets
    wire logic  wr_hit = psel && penable && pready && pwrite && pstrb[0];
    logic       irq_q;
    logic [6:0] kq;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
            kq    <= 7'h00;
        end else if (wr_hit && paddr == 32'h0000_002C) begin
            irq_q <= pwdata[0];
        end else if (wr_hit && paddr == 32'h0000_0028) begin
            kq <= pwdata[6:0];
        end
    end
    // Pads move two edges after the commit
    property p_dir_a; logic [6:0] d; (wr_hit && paddr == 32'h0000_0010, d = pwdata[6:0]) |-> ##2 pa_oe_n == ~d; endproperty
    a_dir_a: assert property (p_dir_a) else $error("port A enable wrong");
    property p_latch_a; logic [6:0] d; (wr_hit && paddr == 32'h0, d = pwdata[6:0]) |-> ##2 pa_out == d; endproperty
    a_latch_a: assert property (p_latch_a) else $error("port A latch not driven");
    property p_dir_c; logic d; (wr_hit && paddr == 32'h0000_0018, d = pwdata[0]) |-> ##2 pc_oe_n[0] == !d; endproperty
    a_dir_c: assert property (p_dir_c) else $error("port C enable wrong");
    property p_rst_dir; $fell(rst) |-> &pa_oe_n && &pb_oe_n && &pc_oe_n; endproperty
    a_rst_dir: assert property (p_rst_dir) else $error("pin driven after reset");
    property p_pull; (pa_pull_up & ~pa_oe_n) == 7'h00; endproperty
    a_pull: assert property (p_pull) else $error("pullup on driven pin");
    property p_irq_rd; irq_q && psel && !penable && paddr == 32'h0000_0008 |=> prdata[2] == 1'b0; endproperty
    a_irq_rd: assert property (p_irq_rd) else $error("port C bit 2 not zero");
    property p_line; !irq_q [*3] |-> line_level; endproperty
    a_line: assert property (p_line) else $error("line level not high");
    property p_key; (keypad_inputs & ~kq & ~$past(kq)) == 7'h00; endproperty
    a_key: assert property (p_key) else $error("keypad input not enabled");
    property p_unmap; psel && !penable && paddr == 32'h0000_000C |=> pready && pslverr && prdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
    c_wr: cover property (wr_hit);
    c_err: cover property (pslverr);
    c_low: cover property ($fell(line_level));
endmodule

bind tpio_ports tpio_ports_chk chk_u (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .pa_out, .pa_oe_n, .pa_pull_up, .pb_oe_n, .pc_oe_n, .keypad_inputs, .line_level);
